// ---- mca_datapath.sv ----
// module: multiplier, product shifter and central alu with a wishbone register port
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

module mca_datapath (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wrap_flag_o,
  output logic             zero_condition_o,
  output logic             jump_o,
  output logic      [15:0] jump_addr_o,
  output logic             move_o,
  output logic      [15:0] move_data_o
);

  // ==========================================================================
  // functions
  function automatic logic [31:0] product_shifter(input logic [31:0] p, input logic [1:0] sel);
    case (sel)
      mca_pkg::PM_NONE:   return p;
      mca_pkg::PM_LEFT1:  return {p[30:0], 1'b0};
      mca_pkg::PM_LEFT4:  return {p[27:0], 4'h0};
      mca_pkg::PM_RIGHT6: return {{6{p[31]}}, p[31:6]};
      default:            return p;
    endcase
  endfunction

  function automatic logic [31:0] input_scaler(input logic [15:0] d, input logic [3:0] sh, input logic sx);
    logic [31:0] e;
    e = sx ? {{16{d[15]}}, d} : {16'h0000, d};
    return e << sh;
  endfunction

  function automatic logic [31:0] multiply(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    logic [31:0] x;
    logic [31:0] y;
    x = sgn ? {{16{a[15]}}, a} : {16'h0000, a};
    y = sgn ? {{16{b[15]}}, b} : {16'h0000, b};
    return x * y;
  endfunction

  function automatic mca_pkg::mca_alu_s alu_addsub(input logic [31:0] a, input logic [31:0] b,
                                                   input logic sub, input logic sat);
    logic [31:0]       s;
    mca_pkg::mca_alu_s r;
    s       = sub ? a - b : a + b;
    r.ovf   = sub ? (a[31] != b[31]) && (s[31] != a[31]) : (a[31] == b[31]) && (s[31] != a[31]);
    r.value = (r.ovf && sat) ? (a[31] ? mca_pkg::SAT_NEG : mca_pkg::SAT_POS) : s;
    return r;
  endfunction

  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // state
  logic [15:0]       data_word;
  logic [15:0]       coef_word;
  logic [15:0]       operand_hold_reg;
  logic [31:0]       product_reg;
  logic [31:0]       running_sum_reg;
  logic              saturate_enable;
  logic              wrap_flag;
  logic [1:0]        product_shift_select;
  logic              sign_extend;
  logic              test_flag;
  logic              branch_taken;
  logic [15:0]       store_word;
  logic              imm_busy;
  logic [31:0]       next_sum;
  mca_pkg::mca_alu_s alu_res;
  logic [31:0]       alu_b;
  logic              alu_sub;
  logic              alu_do;

  // ==========================================================================
  // bus decode
  logic              req;
  logic              wr;
  logic              fire;
  mca_pkg::mca_cmd_s cmd;
  logic [31:0]       shp;
  logic [31:0]       scaled_var;
  logic [31:0]       scaled_cmd;
  logic              ovf_event;

  assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~imm_busy;
  assign wr         = req & wb_we_i;
  assign fire       = wr & (wb_adr_i == mca_pkg::OFS_CMD);
  assign cmd        = mca_pkg::mca_cmd_s'({wb_dat_i[mca_pkg::CMD_SHIFT_LSB +: 4], wb_dat_i[mca_pkg::CMD_OP_LSB +: 5]});
  assign shp        = product_shifter(product_reg, product_shift_select);
  assign scaled_var = input_scaler(data_word, operand_hold_reg[3:0], sign_extend);
  assign scaled_cmd = input_scaler(data_word, cmd.shift, sign_extend);
  assign ovf_event  = fire & alu_do & alu_res.ovf;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        case (wb_adr_i)
          mca_pkg::OFS_DATA:   wb_dat_o <= {16'h0000, data_word};
          mca_pkg::OFS_COEF:   wb_dat_o <= {16'h0000, coef_word};
          mca_pkg::OFS_STAT0:  wb_dat_o <= {26'h000_0000, imm_busy, branch_taken, test_flag,
                                            zero_condition_o, wrap_flag, saturate_enable};
          mca_pkg::OFS_STAT1:  wb_dat_o <= {29'h0000_0000, sign_extend, product_shift_select};
          mca_pkg::OFS_HOLD:   wb_dat_o <= {16'h0000, operand_hold_reg};
          mca_pkg::OFS_PROD:   wb_dat_o <= product_reg;
          mca_pkg::OFS_SUM:    wb_dat_o <= running_sum_reg;
          mca_pkg::OFS_STORE:  wb_dat_o <= {16'h0000, store_word};
          mca_pkg::OFS_SHPROD: wb_dat_o <= shp;
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_word            <= 16'h0000;
      coef_word            <= 16'h0000;
      saturate_enable      <= mca_pkg::RST_SAT;
      product_shift_select <= mca_pkg::RST_PM;
      sign_extend          <= mca_pkg::RST_SXM;
    end else if (wr) begin
      case (wb_adr_i)
        mca_pkg::OFS_DATA:  data_word <= 16'(wb_merge({16'h0000, data_word}, wb_dat_i, wb_sel_i));
        mca_pkg::OFS_COEF:  coef_word <= 16'(wb_merge({16'h0000, coef_word}, wb_dat_i, wb_sel_i));
        mca_pkg::OFS_STAT0: begin
          if (wb_sel_i[0]) begin
            saturate_enable <= wb_dat_i[mca_pkg::ST0_SAT_BIT];
          end
        end
        mca_pkg::OFS_STAT1: begin
          if (wb_sel_i[0]) begin
            product_shift_select <= wb_dat_i[mca_pkg::ST1_PM_LSB +: 2];
            sign_extend          <= wb_dat_i[mca_pkg::ST1_SXM_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // operand hold register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_hold_reg <= 16'h0000;
    end else if (wr && wb_adr_i == mca_pkg::OFS_HOLD) begin
      operand_hold_reg <= 16'(wb_merge({16'h0000, operand_hold_reg}, wb_dat_i, wb_sel_i));
    end else if (fire) begin
      case (cmd.op)
        mca_pkg::OP_LOAD_OPERAND, mca_pkg::OP_LOAD_TAKE_PROD, mca_pkg::OP_LOAD_ADD_PROD,
        mca_pkg::OP_LOAD_SUB_PROD, mca_pkg::OP_LOAD_ADD_MOVE, mca_pkg::OP_MULT_SUM,
        mca_pkg::OP_MULT_SUM_MOVE, mca_pkg::OP_SQUARE_ADD, mca_pkg::OP_SQUARE_SUB:
          operand_hold_reg <= data_word;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // multiplier and product register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      product_reg <= 32'h0000_0000;
      imm_busy    <= 1'b0;
    end else if (imm_busy) begin
      imm_busy    <= 1'b0;
      product_reg <= multiply(operand_hold_reg,
                              {{3{coef_word[mca_pkg::IMM_MSB]}}, coef_word[mca_pkg::IMM_MSB:0]}, 1'b1);
    end else if (fire) begin
      case (cmd.op)
        mca_pkg::OP_SIGNED_MULT:    product_reg <= multiply(operand_hold_reg, data_word, 1'b1);
        mca_pkg::OP_UNSIGNED_MULT:  product_reg <= multiply(operand_hold_reg, data_word, 1'b0);
        mca_pkg::OP_IMM_MULT:       imm_busy    <= 1'b1;
        mca_pkg::OP_MULT_SUM,
        mca_pkg::OP_MULT_SUM_MOVE:  product_reg <= multiply(data_word, coef_word, 1'b1);
        mca_pkg::OP_SQUARE_ADD,
        mca_pkg::OP_SQUARE_SUB:     product_reg <= multiply(data_word, data_word, 1'b1);
        mca_pkg::OP_LOAD_PROD_HIGH: product_reg <= {data_word, product_reg[15:0]};
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // central alu operand select
  always_comb begin
    alu_b   = shp;
    alu_sub = 1'b0;
    alu_do  = 1'b0;
    case (cmd.op)
      mca_pkg::OP_LOAD_ADD_PROD, mca_pkg::OP_LOAD_ADD_MOVE, mca_pkg::OP_MULT_SUM,
      mca_pkg::OP_MULT_SUM_MOVE, mca_pkg::OP_SQUARE_ADD: alu_do = 1'b1;
      mca_pkg::OP_LOAD_SUB_PROD, mca_pkg::OP_SQUARE_SUB: begin
        alu_do  = 1'b1;
        alu_sub = 1'b1;
      end
      mca_pkg::OP_ADD_VAR: begin
        alu_do = 1'b1;
        alu_b  = scaled_var;
      end
      mca_pkg::OP_SUB_VAR: begin
        alu_do  = 1'b1;
        alu_sub = 1'b1;
        alu_b   = scaled_var;
      end
      mca_pkg::OP_ADD_SCALED: begin
        alu_do = 1'b1;
        alu_b  = scaled_cmd;
      end
      mca_pkg::OP_SUB_SCALED: begin
        alu_do  = 1'b1;
        alu_sub = 1'b1;
        alu_b   = scaled_cmd;
      end
      default: ;
    endcase
    alu_res = alu_addsub(running_sum_reg, alu_b, alu_sub, saturate_enable);
  end

  always_comb begin
    case (cmd.op)
      mca_pkg::OP_LOAD_TAKE_PROD: next_sum = shp;
      mca_pkg::OP_LOAD_VAR:       next_sum = scaled_var;
      mca_pkg::OP_LOAD_SCALED:    next_sum = scaled_cmd;
      mca_pkg::OP_AND_SCALED:     next_sum = running_sum_reg & scaled_cmd;
      mca_pkg::OP_OR_SCALED:      next_sum = running_sum_reg | scaled_cmd;
      mca_pkg::OP_XOR_SCALED:     next_sum = running_sum_reg ^ scaled_cmd;
      mca_pkg::OP_LEADING_SHIFT:
        next_sum = (running_sum_reg != 32'h0000_0000 && running_sum_reg[31] == running_sum_reg[30]) ?
                   {running_sum_reg[30:0], 1'b0} : running_sum_reg;
      default:                    next_sum = alu_do ? alu_res.value : running_sum_reg;
    endcase
  end

  // ==========================================================================
  // running sum
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_sum_reg <= 32'h0000_0000;
    end else if (wr && wb_adr_i == mca_pkg::OFS_SUM) begin
      running_sum_reg <= wb_merge(running_sum_reg, wb_dat_i, wb_sel_i);
    end else if (fire) begin
      running_sum_reg <= next_sum;
    end
  end

  // ==========================================================================
  // flags and branch conditions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_flag <= 1'b0;
    end else if (ovf_event) begin
      wrap_flag <= 1'b1;
    end else if (fire && cmd.op == mca_pkg::OP_BRANCH_WRAP) begin
      wrap_flag <= 1'b0;
    end else if (wr && wb_adr_i == mca_pkg::OFS_STAT0 && wb_sel_i[0]) begin
      wrap_flag <= wb_dat_i[mca_pkg::ST0_WRAP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_flag    <= 1'b0;
      branch_taken <= 1'b0;
    end else if (fire) begin
      case (cmd.op)
        mca_pkg::OP_VAR_TEST:      test_flag    <= data_word[4'hf - operand_hold_reg[3:0]];
        mca_pkg::OP_LEADING_SHIFT: test_flag    <= running_sum_reg[31] ^ running_sum_reg[30];
        mca_pkg::OP_BRANCH_WRAP:   branch_taken <= wrap_flag;
        mca_pkg::OP_BRANCH_ZERO:   branch_taken <= zero_condition_o;
        default: ;
      endcase
    end
  end

  assign wrap_flag_o      = wrap_flag;
  assign zero_condition_o = (running_sum_reg == 32'h0000_0000);

  // ==========================================================================
  // data bus side effects: stores, sample moves, jumps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      store_word  <= 16'h0000;
      move_o      <= 1'b0;
      move_data_o <= 16'h0000;
      jump_o      <= 1'b0;
      jump_addr_o <= 16'h0000;
    end else begin
      move_o <= fire && (cmd.op == mca_pkg::OP_LOAD_ADD_MOVE || cmd.op == mca_pkg::OP_MULT_SUM_MOVE);
      jump_o <= fire && cmd.op == mca_pkg::OP_JUMP_TO_SUM;
      if (fire) begin
        case (cmd.op)
          mca_pkg::OP_STORE_HIGH:    store_word  <= shp[31:16];
          mca_pkg::OP_STORE_LOW:     store_word  <= shp[15:0];
          mca_pkg::OP_LOAD_ADD_MOVE,
          mca_pkg::OP_MULT_SUM_MOVE: move_data_o <= data_word;
          mca_pkg::OP_JUMP_TO_SUM:   jump_addr_o <= running_sum_reg[15:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // assertions
  a_signed_product: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && cmd.op == mca_pkg::OP_SIGNED_MULT |=>
      product_reg == multiply($past(operand_hold_reg), $past(data_word), 1'b1))
    else $error("signed product wrong");
  a_unsigned_product: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && cmd.op == mca_pkg::OP_UNSIGNED_MULT |=>
      product_reg == {16'h0000, $past(operand_hold_reg)} * {16'h0000, $past(data_word)})
    else $error("unsigned product wrong");
  a_imm_two_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && cmd.op == mca_pkg::OP_IMM_MULT |=> imm_busy ##1 !imm_busy)
    else $error("immediate multiply not two cycles");
  a_square_same: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && cmd.op == mca_pkg::OP_SQUARE_ADD |=>
      product_reg == multiply($past(data_word), $past(data_word), 1'b1))
    else $error("square operands differ");
  a_store_shifted: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && cmd.op == mca_pkg::OP_STORE_HIGH |=> store_word == $past(shp[31:16]) && $stable(product_reg))
    else $error("store high not shifted product");
  a_sat_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_event && saturate_enable |=> wrap_flag &&
      (running_sum_reg == mca_pkg::SAT_POS || running_sum_reg == mca_pkg::SAT_NEG))
    else $error("overflow not clamped");
  a_logic_no_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (cmd.op == mca_pkg::OP_AND_SCALED || cmd.op == mca_pkg::OP_OR_SCALED ||
             cmd.op == mca_pkg::OP_XOR_SCALED) |=> wrap_flag == $past(wrap_flag))
    else $error("logic op changed overflow flag");
  a_wrap_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap_flag && !wr |=> wrap_flag)
    else $error("overflow flag dropped");
  a_bit_test_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && cmd.op == mca_pkg::OP_VAR_TEST |=> $stable(running_sum_reg))
    else $error("bit test changed sum");
  a_move_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && cmd.op == mca_pkg::OP_MULT_SUM_MOVE |=> move_o && move_data_o == $past(data_word) ##1 !move_o)
    else $error("sample move missing");

  c_mult_sum: cover property (@(posedge clk_i) disable iff (rst_i) fire && cmd.op == mca_pkg::OP_MULT_SUM);
  c_saturate: cover property (@(posedge clk_i) disable iff (rst_i) ovf_event && saturate_enable);
  c_imm_mult: cover property (@(posedge clk_i) disable iff (rst_i) imm_busy);
  c_jump:     cover property (@(posedge clk_i) disable iff (rst_i) jump_o);

endmodule // mca_datapath

`default_nettype wire

// ---- mca_mem_model.sv ----
// data memory and sequencer side model that records sample moves and jumps
`timescale 1ns/100ps
`default_nettype none
module mca_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        move_i,
  input  wire logic [15:0] move_data_i,
  input  wire logic        jump_i,
  input  wire logic [15:0] jump_addr_i,
  output logic      [7:0]  move_count_o,
  output logic      [15:0] last_move_o,
  output logic      [15:0] last_jump_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      move_count_o <= 8'h00;
      last_move_o  <= 16'h0000;
    end else if (move_i) begin
      move_count_o <= move_count_o + 8'h01;
      last_move_o  <= move_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_jump_o <= 16'h0000;
    end else if (jump_i) begin
      last_jump_o <= jump_addr_i;
    end
  end
endmodule // mca_mem_model
`default_nettype wire

// ---- mca_pkg.sv ----
// package: constants, operation codes and carriers for the multiplier and central alu datapath
package mca_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_DATA    = 8'h00;
  localparam logic [7:0] OFS_COEF    = 8'h04;
  localparam logic [7:0] OFS_CMD     = 8'h08;
  localparam logic [7:0] OFS_STAT0   = 8'h0c;
  localparam logic [7:0] OFS_STAT1   = 8'h10;
  localparam logic [7:0] OFS_HOLD    = 8'h14;
  localparam logic [7:0] OFS_PROD    = 8'h18;
  localparam logic [7:0] OFS_SUM     = 8'h1c;
  localparam logic [7:0] OFS_STORE   = 8'h20;
  localparam logic [7:0] OFS_SHPROD  = 8'h24;

  // ==========================================================================
  // field positions
  localparam int ST0_SAT_BIT   = 0;
  localparam int ST0_WRAP_BIT  = 1;
  localparam int ST0_ZERO_BIT  = 2;
  localparam int ST0_TEST_BIT  = 3;
  localparam int ST0_TAKEN_BIT = 4;
  localparam int ST0_BUSY_BIT  = 5;
  localparam int ST1_PM_LSB    = 0;
  localparam int ST1_SXM_BIT   = 2;
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_SHIFT_LSB = 8;
  localparam int IMM_MSB       = 12;

  // ==========================================================================
  // reset values and limits
  localparam logic        RST_SAT  = 1'b0;
  localparam logic        RST_SXM  = 1'b1;
  localparam logic [1:0]  RST_PM   = 2'b00;
  localparam logic [31:0] SAT_POS  = 32'h7fff_ffff;
  localparam logic [31:0] SAT_NEG  = 32'h8000_0000;

  typedef enum logic [1:0] {
    PM_NONE   = 2'b00,
    PM_LEFT1  = 2'b01,
    PM_LEFT4  = 2'b10,
    PM_RIGHT6 = 2'b11
  } mca_pm_e;

  typedef enum logic [4:0] {
    OP_NOP            = 5'b00000,
    OP_LOAD_OPERAND   = 5'b00001,
    OP_LOAD_TAKE_PROD = 5'b00010,
    OP_LOAD_ADD_PROD  = 5'b00011,
    OP_LOAD_SUB_PROD  = 5'b00100,
    OP_LOAD_ADD_MOVE  = 5'b00101,
    OP_SIGNED_MULT    = 5'b00110,
    OP_IMM_MULT       = 5'b00111,
    OP_UNSIGNED_MULT  = 5'b01000,
    OP_MULT_SUM       = 5'b01001,
    OP_MULT_SUM_MOVE  = 5'b01010,
    OP_SQUARE_ADD     = 5'b01011,
    OP_SQUARE_SUB     = 5'b01100,
    OP_STORE_HIGH     = 5'b01101,
    OP_STORE_LOW      = 5'b01110,
    OP_LOAD_PROD_HIGH = 5'b01111,
    OP_LEADING_SHIFT  = 5'b10000,
    OP_LOAD_VAR       = 5'b10001,
    OP_ADD_VAR        = 5'b10010,
    OP_SUB_VAR        = 5'b10011,
    OP_VAR_TEST       = 5'b10100,
    OP_LOAD_SCALED    = 5'b10101,
    OP_ADD_SCALED     = 5'b10110,
    OP_SUB_SCALED     = 5'b10111,
    OP_AND_SCALED     = 5'b11000,
    OP_OR_SCALED      = 5'b11001,
    OP_XOR_SCALED     = 5'b11010,
    OP_BRANCH_WRAP    = 5'b11011,
    OP_BRANCH_ZERO    = 5'b11100,
    OP_JUMP_TO_SUM    = 5'b11101
  } mca_op_e;

  typedef struct packed {
    logic [3:0] shift;
    mca_op_e    op;
  } mca_cmd_s;

  typedef struct packed {
    logic [31:0] value;
    logic        ovf;
  } mca_alu_s;

endpackage

// ---- testbench.sv ----
// testbench: register level checks of the multiplier and central alu datapath
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0, lanes = 4'hf;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, rv;
  logic        ack, wrap, zero, jmp, mv;
  logic [15:0] jadr, mdat, last_mv, last_jmp;
  logic [7:0]  mv_cnt;
  logic [31:0] shexp [4] = '{32'hffff_fffa, 32'hffff_fff4, 32'hffff_ffa0, 32'hffff_ffff};
  int          errors = 0;
  int          samples_checked = 0;
  always #5 clk_i = ~clk_i;
  mca_datapath mca_datapath_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wrap_flag_o(wrap),
    .zero_condition_o(zero), .jump_o(jmp), .jump_addr_o(jadr), .move_o(mv), .move_data_o(mdat));
  mca_mem_model mca_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .move_i(mv), .move_data_i(mdat), .jump_i(jmp),
    .jump_addr_i(jadr), .move_count_o(mv_cnt), .last_move_o(last_mv), .last_jump_o(last_jmp));
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; waits for ack and takes read data at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (n >= 50) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic cmd(input mca_pkg::mca_op_e op);
    bus(1'b1, mca_pkg::OFS_CMD, 32'(op));
  endtask
  task automatic scmd(input mca_pkg::mca_op_e op, input logic [3:0] sh);
    bus(1'b1, mca_pkg::OFS_CMD, {20'h0_0000, sh, 3'b000, op});
  endtask
  task automatic rdchk(input logic [7:0] a, input string nm, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rv);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("zero_rst", 32'h0000_0001, {31'h0000_0000, zero});
    bus(1'b1, mca_pkg::OFS_HOLD, 32'h0000_fffe);
    bus(1'b1, mca_pkg::OFS_DATA, 32'h0000_0003);
    cmd(mca_pkg::OP_SIGNED_MULT);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, mca_pkg::OFS_STAT1, 32'h0000_0004 | i);
      bus(1'b0, mca_pkg::OFS_SHPROD, 32'h0000_0000);
      chk("shprod", shexp[i], rv);
      bus(1'b0, mca_pkg::OFS_PROD, 32'h0000_0000);
      chk("prod", 32'hffff_fffa, rv);
    end
    bus(1'b1, mca_pkg::OFS_STAT1, 32'h0000_0004);
    cmd(mca_pkg::OP_UNSIGNED_MULT);
    bus(1'b0, mca_pkg::OFS_PROD, 32'h0000_0000);
    chk("prod_u", 32'h0002_fffa, rv);
    bus(1'b1, mca_pkg::OFS_COEF, 32'h0000_0000);
    cmd(mca_pkg::OP_IMM_MULT);
    bus(1'b0, mca_pkg::OFS_PROD, 32'h0000_0000);
    chk("prod_imm0", 32'h0000_0000, rv);
    bus(1'b1, mca_pkg::OFS_HOLD, 32'h0000_1234);
    bus(1'b1, mca_pkg::OFS_COEF, 32'h0000_0001);
    cmd(mca_pkg::OP_IMM_MULT);
    cmd(mca_pkg::OP_STORE_LOW);
    bus(1'b0, mca_pkg::OFS_STORE, 32'h0000_0000);
    chk("store_low", 32'h0000_1234, rv);
    bus(1'b1, mca_pkg::OFS_STAT0, 32'h0000_0001);
    bus(1'b1, mca_pkg::OFS_SUM, 32'h7fff_ffff);
    cmd(mca_pkg::OP_LOAD_ADD_PROD);
    chk("wrap_sat", 32'h0000_0001, {31'h0000_0000, wrap});
    bus(1'b0, mca_pkg::OFS_SUM, 32'h0000_0000);
    chk("sum_sat", 32'h7fff_ffff, rv);
    bus(1'b1, mca_pkg::OFS_STAT0, 32'h0000_0000);
    chk("wrap_load", 32'h0000_0000, {31'h0000_0000, wrap});
    bus(1'b1, mca_pkg::OFS_SUM, 32'h7fff_ffff);
    cmd(mca_pkg::OP_LOAD_ADD_PROD);
    bus(1'b0, mca_pkg::OFS_SUM, 32'h0000_0000);
    chk("sum_wrap", 32'h8000_1233, rv);
    chk("wrap_kept", 32'h0000_0001, {31'h0000_0000, wrap});
    cmd(mca_pkg::OP_BRANCH_WRAP);
    cmd(mca_pkg::OP_AND_SCALED);
    chk("wrap_logic", 32'h0000_0000, {31'h0000_0000, wrap});
    bus(1'b1, mca_pkg::OFS_SUM, 32'h0000_abcd);
    cmd(mca_pkg::OP_JUMP_TO_SUM);
    bus(1'b1, mca_pkg::OFS_DATA, 32'h0000_0055);
    chk("jump", 32'h0000_abcd, {16'h0000, last_jmp});
    bus(1'b1, mca_pkg::OFS_COEF, 32'h0000_0002);
    cmd(mca_pkg::OP_MULT_SUM_MOVE);
    cmd(mca_pkg::OP_LOAD_ADD_MOVE);
    bus(1'b1, mca_pkg::OFS_SUM, 32'h0000_0000);
    chk("moves", 32'h0000_0002, {24'h00_0000, mv_cnt});
    chk("moved", 32'h0000_0055, {16'h0000, last_mv});
    chk("zero", 32'h0000_0001, {31'h0000_0000, zero});
    bus(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rv);
    lanes = 4'h2;
    bus(1'b1, mca_pkg::OFS_DATA, 32'h1234_80ff);
    lanes = 4'hf;
    rdchk(mca_pkg::OFS_DATA, "data_lane", 32'h0000_8055);
    bus(1'b1, mca_pkg::OFS_DATA, 32'h0000_8000);
    cmd(mca_pkg::OP_SQUARE_ADD);
    rdchk(mca_pkg::OFS_SUM, "sum_square_add_op", 32'h0000_00aa);
    rdchk(mca_pkg::OFS_PROD, "prod_square_add_op", 32'h4000_0000);
    bus(1'b1, mca_pkg::OFS_STAT1, 32'h0000_0005);
    cmd(mca_pkg::OP_STORE_HIGH);
    rdchk(mca_pkg::OFS_STORE, "store_high", 32'h0000_8000);
    rdchk(mca_pkg::OFS_PROD, "prod_kept", 32'h4000_0000);
    cmd(mca_pkg::OP_SQUARE_SUB);
    rdchk(mca_pkg::OFS_SUM, "sum_square_sub_op", 32'h8000_00aa);
    chk("wrap_square_sub_op", 32'h0000_0001, {31'h0000_0000, wrap});
    cmd(mca_pkg::OP_BRANCH_WRAP);
    cmd(mca_pkg::OP_VAR_TEST);
    rdchk(mca_pkg::OFS_STAT0, "stat0_test", 32'h0000_0018);
    bus(1'b1, mca_pkg::OFS_SUM, 32'h0000_1000);
    cmd(mca_pkg::OP_LEADING_SHIFT);
    rdchk(mca_pkg::OFS_SUM, "sum_leading_shift_op", 32'h0000_2000);
    cmd(mca_pkg::OP_BRANCH_ZERO);
    rdchk(mca_pkg::OFS_STAT0, "stat0_leading_shift_op", 32'h0000_0000);
    bus(1'b1, mca_pkg::OFS_SUM, 32'h0000_0000);
    cmd(mca_pkg::OP_BRANCH_ZERO);
    rdchk(mca_pkg::OFS_STAT0, "stat0_zero", 32'h0000_0014);
    scmd(mca_pkg::OP_LOAD_SCALED, 4'h4);
    rdchk(mca_pkg::OFS_SUM, "sum_lds", 32'hfff8_0000);
    bus(1'b1, mca_pkg::OFS_STAT1, 32'h0000_0001);
    scmd(mca_pkg::OP_ADD_SCALED, 4'h4);
    chk("zero_adds", 32'h0000_0001, {31'h0000_0000, zero});
    scmd(mca_pkg::OP_SUB_SCALED, 4'h0);
    rdchk(mca_pkg::OFS_SUM, "sum_subs", 32'hffff_8000);
    bus(1'b1, mca_pkg::OFS_STAT1, 32'h0000_0004);
    bus(1'b1, mca_pkg::OFS_HOLD, 32'h0000_0003);
    cmd(mca_pkg::OP_LOAD_VAR);
    cmd(mca_pkg::OP_ADD_VAR);
    rdchk(mca_pkg::OFS_SUM, "sum_add_with_var_shift", 32'hfff8_0000);
    cmd(mca_pkg::OP_SUB_VAR);
    rdchk(mca_pkg::OFS_SUM, "sum_sub_with_var_shift", 32'hfffc_0000);
    bus(1'b1, mca_pkg::OFS_DATA, 32'h0000_0f0f);
    scmd(mca_pkg::OP_XOR_SCALED, 4'h0);
    scmd(mca_pkg::OP_OR_SCALED, 4'h4);
    scmd(mca_pkg::OP_AND_SCALED, 4'h0);
    rdchk(mca_pkg::OFS_SUM, "sum_logic", 32'h0000_0f0f);
    chk("wrap_bool", 32'h0000_0000, {31'h0000_0000, wrap});
    cmd(mca_pkg::OP_LOAD_TAKE_PROD);
    rdchk(mca_pkg::OFS_SUM, "sum_ltp", 32'h4000_0000);
    cmd(mca_pkg::OP_LOAD_SUB_PROD);
    chk("zero_lts", 32'h0000_0001, {31'h0000_0000, zero});
    bus(1'b1, mca_pkg::OFS_DATA, 32'h0000_0002);
    cmd(mca_pkg::OP_LOAD_OPERAND);
    rdchk(mca_pkg::OFS_HOLD, "hold_lt", 32'h0000_0002);
    cmd(mca_pkg::OP_MULT_SUM);
    rdchk(mca_pkg::OFS_PROD, "prod_mac", 32'h0000_0004);
    rdchk(mca_pkg::OFS_SUM, "sum_mac", 32'h4000_0000);
    bus(1'b1, mca_pkg::OFS_HOLD, 32'h0000_def0);
    bus(1'b1, mca_pkg::OFS_COEF, 32'h0000_0001);
    cmd(mca_pkg::OP_IMM_MULT);
    bus(1'b1, mca_pkg::OFS_DATA, 32'h0000_9abc);
    cmd(mca_pkg::OP_LOAD_PROD_HIGH);
    rdchk(mca_pkg::OFS_PROD, "prod_restore", 32'h9abc_def0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(mca_pkg::OFS_STAT1, "stat1_rst", 32'h0000_0004);
    rdchk(mca_pkg::OFS_STAT0, "stat0_rst", 32'h0000_0004);
    rdchk(mca_pkg::OFS_PROD, "prod_rst", 32'h0000_0000);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
